/* rtl/srl_pkg.sv */
// Purpose: shared constants for the serial register write link
// Assumes: system clock of 20 MHz, link bit rate well below it
// Notes: register contents and LED logic live outside this block
// Contract
// R1: write-only link, never drives read data
// R2: bytes are eight bits, MSB first
// R3: first byte is address; 00h general call
// R4: second byte sets pointer, then auto-increment
// R5: address is six strap pins, upper zero
// R6: all straps high disables register writes
// R7: host stays within registers 00h to 18h
// R8: host straps addresses 01h to 3Eh
// R9: three-wire pins: select, clock, data, neg low
// R10: three-wire samples data on rising clock
// R11: three-wire last byte commits on select rise
// R12: early select rise discards partial byte
// R13: pair mode samples rising clock, data moves low
// R14: data fall with clock high is header
// R15: last byte commits on end pulse rise
// R16: header mid-byte discards partial byte
// R17: bridge forwards data with setup lead
// R18: bridge emits header on select fall
// R19: bridge forces data high, adds end pulse
// R20: repeater retimes data and regenerates header
// R21: host initialises pair links with long select pulse
// R22: counters clear at every frame start
package srl_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 6;
    localparam logic [7:0] GENERAL_CALL = 8'h00;
    localparam logic [7:0] EXCLUDED_ADDR = 8'h3F;
    localparam logic [5:0] STRAP_ALL_HIGH = 6'h3F;
    localparam logic [7:0] LAST_REG = 8'h18;
    localparam int SETUP_NS = 10;
    localparam int END_PULSE_NS = 40;
    localparam int SETUP_CYC = (SETUP_NS * CLK_HZ / 1_000_000_000) < 1 ? 1 :
        SETUP_NS * CLK_HZ / 1_000_000_000;
    localparam int END_PULSE_CYC = (END_PULSE_NS * CLK_HZ / 1_000_000_000) < 1 ? 1 :
        END_PULSE_NS * CLK_HZ / 1_000_000_000;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W = 16;
endpackage

/* rtl/srl_sync.sv */
// Purpose: two-flop synchroniser for one pin
// Assumes: input asynchronous to clk_in
// Notes: first flop read only by the second
`timescale 1ns/1ns
module srl_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

/* rtl/srl_fifo.sv */
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: single clock
// Notes: full and empty are exact
`timescale 1ns/1ns
module srl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign in_ready_out = (cnt_r != DEPTH[AW:0]);
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out = mem_r[rd_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

/* rtl/srl_link.sv */
// Purpose: serial register write front end with bridge and repeater output
// Assumes: link pins asynchronous, sampled by sys_clk_in
// Notes: writes leave through a FIFO as {pointer, value}
`timescale 1ns/1ns
module srl_link #(
    parameter int FIFO_DEPTH = srl_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic three_wire_mode_in,
    input wire logic link_clock_in_pos,
    input wire logic link_clock_in_neg,
    input wire logic link_data_in_pos,
    input wire logic link_data_in_neg,
    input wire logic [5:0] address_strap_pins,
    output logic link_clock_out,
    output logic link_data_out,
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output logic overflow_out
);
    typedef enum logic [1:0] {
        SRL_IDLE, SRL_DEV, SRL_PTR, SRL_DATA
    } srl_state_t;
    typedef enum logic [2:0] {
        SRL_TX_IDLE, SRL_TX_HDR, SRL_TX_RUN, SRL_TX_ENDHI, SRL_TX_ENDLO, SRL_TX_ENDUP,
        SRL_TX_REHDR
    } srl_tx_t;
    // longest clock low, in system clocks, still taken as an end pulse
    localparam logic [2:0] SHORT_LOW_MAX = 3'h2;

    logic ck_s, dp_s, dn_s, cs_s, mode_s;
    logic [5:0] strap_s;
    logic ck_d_r, dp_d_r, cs_d_r;

    srl_sync u_sck (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(link_clock_in_pos),
        .q_out(ck_s));
    srl_sync u_scn (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(link_clock_in_neg),
        .q_out(cs_s));
    srl_sync u_sdp (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(link_data_in_pos),
        .q_out(dp_s));
    srl_sync u_sdn (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(link_data_in_neg),
        .q_out(dn_s));
    srl_sync u_smd (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(three_wire_mode_in),
        .q_out(mode_s));
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_strap
            srl_sync u_sa (.clk_in(sys_clk_in), .rst_in(rst_in),
                .d_in(address_strap_pins[gi]), .q_out(strap_s[gi]));
        end
    endgenerate

    // differential pair: logical level is pos above neg; cs shares the neg clock pin
    logic pair_clk, pair_dat;
    assign pair_clk = mode_s ? ck_s : (ck_s & ~cs_s);
    assign pair_dat = mode_s ? dp_s : (dp_s & ~dn_s);
    logic pair_clk_d_r;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ck_d_r <= 1'b0;
            dp_d_r <= 1'b1;
            cs_d_r <= 1'b1;
            pair_clk_d_r <= 1'b1;
        end else begin
            ck_d_r <= pair_clk;
            dp_d_r <= pair_dat;
            cs_d_r <= cs_s;
            pair_clk_d_r <= pair_clk;
        end
    end

    // frame events
    logic clk_rise, clk_fall_pair, clk_rise_pair;
    logic frame_start, frame_end, bit_take;
    assign clk_rise = pair_clk && !ck_d_r;
    assign clk_rise_pair = pair_clk && !pair_clk_d_r;
    assign clk_fall_pair = !pair_clk && pair_clk_d_r;
    logic sel_fall, sel_rise, hdr_seen;
    assign sel_fall = mode_s && !cs_s && cs_d_r; // R18
    assign sel_rise = mode_s && cs_s && !cs_d_r;
    assign hdr_seen = !mode_s && pair_clk && pair_clk_d_r && !pair_dat && dp_d_r; // R14
    logic end_rise;
    logic in_frame_r;
    logic [2:0] lo_cnt_r;
    // end pulse told from a bit by its short low phase with data high; bits keep the
    // clock low for four system clocks or more, so a 40 ns pulse may be missed
    assign end_rise = !mode_s && clk_rise_pair && pair_dat && in_frame_r &&
        lo_cnt_r <= SHORT_LOW_MAX; // R15
    assign frame_start = sel_fall || hdr_seen; // R22
    assign frame_end = sel_rise || end_rise; // R11 R15
    assign bit_take = mode_s ? (!cs_s && clk_rise) : (clk_rise && !end_rise); // R10 R13

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            in_frame_r <= 1'b0;
        end else if (frame_start) begin
            in_frame_r <= 1'b1;
        end else if (frame_end) begin
            in_frame_r <= 1'b0;
        end
    end

    // width of the present low phase of the pair clock, saturating
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            lo_cnt_r <= '0;
        end else if (pair_clk) begin
            lo_cnt_r <= '0;
        end else if (lo_cnt_r != 3'h7) begin
            lo_cnt_r <= lo_cnt_r + 3'h1;
        end
    end

    // byte assembly
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] held_byte_r;
    logic held_r;
    logic [1:0] byte_cnt_r;
    logic byte_done;
    assign byte_done = bit_take && in_frame_r && bit_cnt_r == 3'd7;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bit_cnt_r <= '0;
            shift_r <= '0;
        end else if (frame_start || frame_end) begin
            bit_cnt_r <= '0; // R12 R16 R22
        end else if (bit_take && in_frame_r) begin
            shift_r <= {shift_r[6:0], pair_dat}; // R2
            bit_cnt_r <= bit_cnt_r + 3'd1;
        end
    end

    // address / pointer parsing
    logic [7:0] dev_addr;
    logic selected_r;
    logic [7:0] ptr_r;
    logic [7:0] fresh_byte;
    assign dev_addr = {2'b00, strap_s}; // R5
    assign fresh_byte = {shift_r[6:0], pair_dat};
    logic commit_now;
    logic [7:0] commit_val;
    logic fifo_ready;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            byte_cnt_r <= '0;
            selected_r <= 1'b0;
            ptr_r <= '0;
            held_r <= 1'b0;
            held_byte_r <= '0;
        end else if (frame_start) begin
            byte_cnt_r <= '0; // R22
            held_r <= 1'b0;
        end else if (frame_end) begin
            held_r <= 1'b0; // R11 R15
            if (held_r) begin
                ptr_r <= ptr_r + 8'd1;
            end
        end else if (byte_done) begin
            unique case (byte_cnt_r)
                2'd0: begin
                    selected_r <= strap_s != srl_pkg::STRAP_ALL_HIGH && // R6
                        (fresh_byte == dev_addr ||
                         (fresh_byte == srl_pkg::GENERAL_CALL &&
                          dev_addr != srl_pkg::EXCLUDED_ADDR)); // R3
                    byte_cnt_r <= 2'd1;
                end
                2'd1: begin
                    ptr_r <= fresh_byte; // R4
                    byte_cnt_r <= 2'd2;
                end
                default: begin
                    // a held byte is written once the next one proves it was not last
                    if (held_r) begin
                        ptr_r <= ptr_r + 8'd1; // R4
                    end
                    held_byte_r <= fresh_byte;
                    held_r <= 1'b1;
                end
            endcase
        end
    end

    assign commit_now = selected_r && held_r && (frame_end || (byte_done && byte_cnt_r == 2'd2));
    assign commit_val = held_byte_r;

    // writes queue in the FIFO; a full FIFO drops and flags
    logic [15:0] fifo_out;
    logic fifo_valid;
    srl_fifo #(.WIDTH(srl_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(commit_now),
        .in_ready_out(fifo_ready),
        .in_data_in({ptr_r, commit_val}),
        .out_valid_out(fifo_valid),
        .out_ready_in(wr_ready_in && !wr_valid_out),
        .out_data_out(fifo_out)
    );

    // output stage registered; R1: no read path exists
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_valid_out <= 1'b0;
            wr_addr_out <= '0;
            wr_data_out <= '0;
            overflow_out <= 1'b0;
        end else begin
            if (wr_valid_out && wr_ready_in) begin
                wr_valid_out <= 1'b0;
            end else if (fifo_valid && wr_ready_in && !wr_valid_out) begin
                wr_valid_out <= 1'b1;
                wr_addr_out <= fifo_out[15:8];
                wr_data_out <= fifo_out[7:0];
            end
            if (commit_now && !fifo_ready) begin
                overflow_out <= 1'b1;
            end
        end
    end

    // bridge / repeater transmitter
    srl_tx_t tx_r;
    logic [3:0] tmr_r;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tx_r <= SRL_TX_IDLE;
            tmr_r <= '0;
            link_clock_out <= 1'b1;
            link_data_out <= 1'b1;
        end else begin
            if (tmr_r != '0) begin
                tmr_r <= tmr_r - 4'd1;
            end
            unique case (tx_r)
                SRL_TX_IDLE: begin
                    link_clock_out <= 1'b1;
                    if (frame_start) begin
                        link_data_out <= 1'b0; // R18 R20
                        tx_r <= SRL_TX_HDR;
                    end else begin
                        link_data_out <= 1'b1;
                    end
                end
                SRL_TX_HDR: begin
                    link_clock_out <= 1'b0;
                    tx_r <= SRL_TX_RUN;
                end
                SRL_TX_RUN: begin
                    if (!mode_s && hdr_seen) begin
                        // data up first so the regenerated header is a clean fall
                        link_data_out <= 1'b1; // R20
                        tx_r <= SRL_TX_REHDR;
                    end else if (frame_end) begin
                        link_data_out <= 1'b1; // R19
                        link_clock_out <= 1'b0;
                        tmr_r <= 4'(srl_pkg::SETUP_CYC);
                        tx_r <= SRL_TX_ENDUP;
                    end else if (bit_take) begin
                        // data placed one cycle before the clock rise gives setup lead
                        link_data_out <= pair_dat; // R17 R20
                        link_clock_out <= 1'b0;
                        tmr_r <= 4'(srl_pkg::SETUP_CYC);
                        tx_r <= SRL_TX_ENDHI;
                    end else if (mode_s ? !pair_clk : clk_fall_pair) begin
                        link_clock_out <= 1'b0;
                    end
                end
                SRL_TX_REHDR: begin
                    link_clock_out <= 1'b1;
                    if (link_clock_out) begin
                        link_data_out <= 1'b0; // R20
                        tx_r <= SRL_TX_HDR;
                    end
                end
                SRL_TX_ENDUP: begin
                    // clock high with data high, then the short low pulse
                    if (tmr_r <= 4'd1) begin
                        link_clock_out <= 1'b1; // R19
                        tmr_r <= '0;
                        tx_r <= SRL_TX_ENDLO;
                    end
                end
                SRL_TX_ENDHI: begin
                    if (tmr_r == 4'd1) begin
                        link_clock_out <= 1'b1;
                        tx_r <= SRL_TX_RUN;
                    end
                end
                SRL_TX_ENDLO: begin
                    link_clock_out <= 1'b0;
                    if (tmr_r == 4'd0) begin
                        tmr_r <= 4'(srl_pkg::END_PULSE_CYC);
                    end
                    if (tmr_r == 4'd1) begin
                        link_clock_out <= 1'b1; // R19
                        tx_r <= SRL_TX_IDLE;
                    end
                end
                default: tx_r <= SRL_TX_IDLE;
            endcase
        end
    end
endmodule

/* tb/srl_link_props.sv */
// Purpose: concurrent checks on the link ports
// Assumes: bridge and repeater latency under twelve system clocks
// Notes: end pulse is one system clock wide at 20 MHz
`timescale 1ns/1ns
module srl_link_props (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic three_wire_mode_in,
    input wire logic link_clock_in_pos,
    input wire logic link_clock_in_neg,
    input wire logic link_data_in_pos,
    input wire logic [5:0] address_strap_pins,
    input wire logic link_clock_out,
    input wire logic link_data_out,
    input wire logic wr_valid_out,
    input wire logic wr_ready_in,
    input wire logic [7:0] wr_addr_out,
    input wire logic [7:0] wr_data_out,
    input wire logic overflow_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_valid_holds: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out &&
        $stable(wr_addr_out) && $stable(wr_data_out)) else $error("write changed while held");
    a_ptr_in_range: assert property (wr_valid_out |-> wr_addr_out <= srl_pkg::LAST_REG)
        else $error("write pointer out of range");
    a_strap_blocks: assert property (
        wr_valid_out |-> address_strap_pins != srl_pkg::STRAP_ALL_HIGH)
        else $error("write with all straps high");
    a_setup_lead: assert property ($rose(link_clock_out) |-> $stable(link_data_out))
        else $error("data moved with output clock rise");
    a_short_pulse: assert property (
        $fell(link_clock_out) ##1 $rose(link_clock_out) |-> link_data_out)
        else $error("end pulse with data low");
    a_end_data_high: assert property (three_wire_mode_in && $rose(link_clock_in_neg) |->
        ##[1:12] ($rose(link_clock_out) && link_data_out)) else $error("no end pulse");
    a_bridge_header: assert property (three_wire_mode_in && $fell(link_clock_in_neg) |->
        ##[1:12] ($fell(link_data_out) && link_clock_out)) else $error("no bridge header");
    a_repeat_header: assert property (!three_wire_mode_in && link_clock_in_pos &&
        $fell(link_data_in_pos) |-> ##[1:12] ($fell(link_data_out) && link_clock_out))
        else $error("header not regenerated");
    c_write: cover property (wr_valid_out && wr_ready_in);
    c_overflow: cover property ($rose(overflow_out));
    c_end_pulse: cover property ($fell(link_clock_out) ##1 $rose(link_clock_out));
endmodule
bind srl_link srl_link_props u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .three_wire_mode_in(three_wire_mode_in), .link_clock_in_pos(link_clock_in_pos),
    .link_clock_in_neg(link_clock_in_neg), .link_data_in_pos(link_data_in_pos),
    .address_strap_pins(address_strap_pins), .link_clock_out(link_clock_out),
    .link_data_out(link_data_out), .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in),
    .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .overflow_out(overflow_out));

/* tb/srl_host_model.sv */
// Purpose: host or upstream stage driving the link pins
// Assumes: half bit period 200 ns, equal to four system clocks
// Notes: clock stands still between frames
`timescale 1ns/1ns
module srl_host_model (
    input wire logic pair_in,
    output logic clk_p_out,
    output logic clk_n_out,
    output logic dat_p_out,
    output logic dat_n_out
);
    logic sel_n = 1'b1;
    logic sck = 1'b0;
    logic sd = 1'b1;
    assign clk_p_out = sck;
    assign clk_n_out = pair_in ? ~sck : sel_n;
    assign dat_p_out = sd;
    assign dat_n_out = pair_in ? ~sd : 1'b0;
    task automatic start();
        #13;
        if (pair_in) begin
            sd = 1'b1;
            #100 sck = 1'b1;
            #200 sd = 1'b0;
            #200 sck = 1'b0;
        end else begin
            sck = 1'b0;
            #200 sel_n = 1'b0;
            #200;
        end
        #100;
    endtask
    // data only moves while the clock is low
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            sd = v[31-i];
            #100 sck = 1'b1;
            #200 sck = 1'b0;
            #100;
        end
    endtask
    task automatic finish();
        if (pair_in) begin
            sd = 1'b1;
            #100 sck = 1'b1;
            #200 sck = 1'b0;
            #100 sck = 1'b1;
        end else begin
            #200 sel_n = 1'b1;
            sd = ~sd;
        end
        #400;
    endtask
    // clock low before leaving pair mode, so select does not appear to rise
    task automatic park();
        #13 sck = 1'b0;
        #400;
    endtask
endmodule

/* tb/srl_link_test.sv */
// Purpose: self-checking bench for the serial register write link
// Assumes: FIFO depth cut to four so overflow comes quickly
// Notes: link pins come from the host model, off the clock edge
`timescale 1ns/1ns
module srl_link_test;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic mode_r = 1'b1;
    logic stall_r = 1'b0;
    logic ready_r = 1'b0;
    logic [5:0] strap_r = 6'h05;
    logic cp, cn, dp, dn, clk_out, dat_out, wr_valid, ovf;
    logic [7:0] wr_addr, wr_data;
    logic [15:0] got[$];
    int err_count = 0;
    int tests_run = 0;
    always #25 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) ready_r <= stall_r ? 1'b0 : ~ready_r;
    always @(posedge sys_clk_in) begin
        if (!rst_in && wr_valid === 1'b1 && ready_r === 1'b1)
            got.push_back({wr_addr, wr_data});
    end
    srl_host_model u_host (.pair_in(~mode_r), .clk_p_out(cp), .clk_n_out(cn),
        .dat_p_out(dp), .dat_n_out(dn));
    srl_link #(.FIFO_DEPTH(4)) u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .three_wire_mode_in(mode_r), .link_clock_in_pos(cp), .link_clock_in_neg(cn),
        .link_data_in_pos(dp), .link_data_in_neg(dn), .address_strap_pins(strap_r),
        .link_clock_out(clk_out), .link_data_out(dat_out), .wr_valid_out(wr_valid),
        .wr_ready_in(ready_r), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
        .overflow_out(ovf));
    task automatic results();
        if (err_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic fail(input string m);
        $display("[FAIL] %0t %s", $time, m);
        err_count++;
    endtask
    // negative count skips the count, for drops whose number is open
    task automatic check(input int n, input logic [15:0] e0, input logic [15:0] e1);
        repeat (60) @(posedge sys_clk_in);
        tests_run++;
        if (n >= 0 && got.size() != n) fail("write count");
        else if (n != 0 && got.size() > 0 && got[0] !== e0) fail("first write");
        else if ((n > 1 || n < 0) && got.size() > 1 && got[1] !== e1) fail("second write");
        got.delete();
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] p, input logic [15:0] v);
        u_host.start();
        u_host.bits({a, p, v}, 32);
        u_host.finish();
    endtask
    task automatic t_three_wire();
        u_host.start();
        u_host.bits({8'h05, 8'h17, 16'hA53C}, 32);
        check(1, 16'h17A5, 16'h0000);
        u_host.finish();
        check(1, 16'h183C, 16'h0000);
    endtask
    task automatic t_select();
        logic [5:0] st [5] = '{6'h05, 6'h05, 6'h3F, 6'h3F, 6'h3E};
        logic [7:0] ad [5] = '{8'h00, 8'h06, 8'h00, 8'h3F, 8'h3E};
        int nx [5] = '{2, 0, 0, 0, 2};
        for (int i = 0; i < 5; i++) begin
            strap_r <= st[i];
            @(posedge sys_clk_in);
            frame(ad[i], 8'h02, 16'h1122);
            check(nx[i], 16'h0211, 16'h0322);
        end
    endtask
    task automatic t_partial();
        u_host.start();
        u_host.bits({8'h3E, 8'h01, 16'hFFFF}, 20);
        u_host.finish();
        frame(8'h3E, 8'h01, 16'h7788);
        check(2, 16'h0177, 16'h0288);
    endtask
    task automatic t_pair();
        u_host.start();
        u_host.finish();
        mode_r <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        frame(8'h3E, 8'h10, 16'h5AC3);
        check(2, 16'h105A, 16'h11C3);
        u_host.start();
        u_host.bits({8'h3E, 8'h05, 16'hFFFF}, 20);
        u_host.start();
        u_host.bits({8'h3E, 8'h06, 16'h0102}, 32);
        u_host.finish();
        check(2, 16'h0601, 16'h0702);
    endtask
    task automatic t_fifo();
        u_host.park();
        @(posedge sys_clk_in);
        mode_r <= 1'b1;
        stall_r <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        u_host.start();
        u_host.bits({8'h3E, 8'h00, 16'h0A0B}, 32);
        u_host.bits(32'h0C0D0E0F, 32);
        u_host.finish();
        repeat (60) @(posedge sys_clk_in);
        tests_run++;
        if (ovf !== 1'b1) fail("no overflow");
        stall_r <= 1'b0;
        check(4, 16'h000A, 16'h010B);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        t_three_wire();
        t_select();
        t_partial();
        t_pair();
        t_fifo();
        results();
    end
    initial begin
        #2_000_000;
        fail("timeout");
        results();
    end
endmodule
